// ### rtl/acb_pkg.sv
`default_nettype none
package acb_pkg;

  // ***********************************
  // register indices within a page
  // ***********************************
  localparam logic [6:0] PAGE_IDX       = 7'h00;
  localparam logic [6:0] CFG_IDX        = 7'h01;
  localparam logic [6:0] COEF_FIRST_IDX = 7'h08;
  localparam logic [6:0] COEF_LAST_IDX  = 7'h7F;

  // ***********************************
  // pages
  // ***********************************
  localparam logic [7:0] REC_A_PG      = 8'h08;
  localparam logic [7:0] REC_B_PG      = 8'h1A;
  localparam logic [7:0] PLAY_A_PG     = 8'h2C;
  localparam logic [7:0] PLAY_B_PG     = 8'h3E;
  localparam logic [7:0] PAGES_PER_BUF = 8'h09;
  localparam logic [7:0] BYTES_PER_PG  = 8'h78;
  localparam int         BUF_BYTES     = 1080;
  localparam int         NUM_COEFS     = 256;

  // ***********************************
  // configuration register fields and resets
  // ***********************************
  localparam int         CFG_EN_BIT   = 2;
  localparam int         CFG_OWN_BIT  = 1;
  localparam int         CFG_SWAP_BIT = 0;
  localparam logic [7:0] PAGE_RST     = 8'h00;
  localparam logic       CFG_EN_RST   = 1'b0;
  localparam logic       CFG_OWN_RST  = 1'b0;
  localparam logic       CFG_SWAP_RST = 1'b0;

  // ***********************************
  // coefficient location decode
  // ***********************************
  typedef struct packed {
    logic        hit;
    logic        path;   // 0 record, 1 playback
    logic        bsel;   // 0 buffer A, 1 buffer B
    logic [10:0] addr;
  } acb_loc_s;

  function automatic acb_loc_s acb_decode(input logic [7:0] page, input logic [6:0] idx);
    acb_loc_s   l;
    logic [7:0] rel;
    l   = '0;
    rel = 8'h00;
    if (page >= REC_A_PG && page < REC_A_PG + PAGES_PER_BUF) begin
      l.hit = 1'b1; l.path = 1'b0; l.bsel = 1'b0; rel = page - REC_A_PG;
    end else if (page >= REC_B_PG && page < REC_B_PG + PAGES_PER_BUF) begin
      l.hit = 1'b1; l.path = 1'b0; l.bsel = 1'b1; rel = page - REC_B_PG;
    end else if (page >= PLAY_A_PG && page < PLAY_A_PG + PAGES_PER_BUF) begin
      l.hit = 1'b1; l.path = 1'b1; l.bsel = 1'b0; rel = page - PLAY_A_PG;
    end else if (page >= PLAY_B_PG && page < PLAY_B_PG + PAGES_PER_BUF) begin
      l.hit = 1'b1; l.path = 1'b1; l.bsel = 1'b1; rel = page - PLAY_B_PG;
    end
    l.hit  = l.hit & (idx >= COEF_FIRST_IDX);
    l.addr = 11'(rel) * 11'(BYTES_PER_PG) + 11'(idx - COEF_FIRST_IDX);
    return l;
  endfunction : acb_decode

endpackage : acb_pkg
`default_nettype wire

// ### rtl/acb_coef_bank.sv
`timescale 1ns/10ps
`default_nettype none
module acb_coef_bank #(
  parameter int DEPTH = acb_pkg::BUF_BYTES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // host byte port
  input  wire logic        host_we,
  input  wire logic        host_buf,
  input  wire logic [10:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  // filter engine port
  input  wire logic        eng_buf,
  input  wire logic [7:0]  eng_idx,
  output logic      [23:0] eng_coef
);

  // ***********************************
  // storage: two buffers, contents undefined after reset
  // ***********************************
  logic [7:0]  mem [2][DEPTH];
  logic [10:0] eng_base;
  logic [23:0] eng_coef_nxt;

  if (DEPTH < 4 * acb_pkg::NUM_COEFS || DEPTH > 2047) begin : g_chk
    $error("acb_coef_bank: DEPTH cannot hold every coefficient");
  end

  assign host_rdata   = mem[host_buf][host_addr];
  // each coefficient takes four bytes: msb first, fourth byte pads
  assign eng_base     = {1'b0, eng_idx, 2'b00};
  assign eng_coef_nxt = {mem[eng_buf][eng_base], mem[eng_buf][eng_base + 11'h001],
                         mem[eng_buf][eng_base + 11'h002]};

  always_ff @(posedge pclk) begin
    if (host_we) begin
      mem[host_buf][host_addr] <= host_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_coef <= 24'h000000;
    end else begin
      eng_coef <= eng_coef_nxt;
    end
  end

endmodule : acb_coef_bank
`default_nettype wire

// ### rtl/acb_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// - page pointer selects page, resets zero
// - page pointer at index zero everywhere
// - enable bit two switches adaptive buffering
// - bit one reports which buffer filter owns in adaptive mode
// - writing bit zero requests swap if enabled
// - swap request clears itself after swap
// - page 44 holds playback A head
// - playback gated by power when not adaptive
// - pages 9-16 hold record A tail
// - record gated by power when not adaptive
// - pages 26-34 hold record buffer B
// - reserved registers and bits read zero
// - record config mirrors playback config
// - page 8 holds record A head
// - pages 45-52 hold playback A tail
// - pages 62-70 hold playback buffer B
module acb_ctrl #(
  parameter int ADDR_W = 12
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // record filter engine
  input  wire logic              rec_pwr_up,
  input  wire logic              rec_frame,
  input  wire logic [7:0]        rec_coef_idx,
  output logic      [23:0]       rec_coef,
  // playback filter engine
  input  wire logic              play_pwr_up,
  input  wire logic              play_frame,
  input  wire logic [7:0]        play_coef_idx,
  output logic      [23:0]       play_coef
);

  if (ADDR_W < 9 || ADDR_W > 32) begin : g_chk
    $error("acb_ctrl: ADDR_W must be 9 to 32");
  end

  // ***********************************
  // state
  // ***********************************
  logic [7:0]  page_r;
  logic [1:0]  en_r;
  logic [1:0]  own_r;
  logic [1:0]  req_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  logic [7:0]  page_nxt;
  logic [1:0]  en_nxt;
  logic [1:0]  own_nxt;
  logic [1:0]  req_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;

  // ***********************************
  // address decode
  // ***********************************
  wire logic               setup;
  wire logic               acc_wr;
  wire logic [6:0]         idx;
  wire logic               bad_addr;
  wire acb_pkg::acb_loc_s  loc;
  wire logic [1:0]         cfg_hit;
  wire logic [1:0]         cfg_wr;
  wire logic               page_hit;
  wire logic               blocked;
  wire logic               host_buf;
  wire logic [1:0]         pwr_up;
  wire logic [1:0]         frame;
  wire logic [1:0]         swap;
  wire logic [1:0]         eng_buf;
  wire logic [1:0]         bank_we;
  wire logic [7:0]         bank_rd [2];
  wire logic [7:0]         eng_idx [2];
  wire logic [23:0]        eng_coef [2];
  wire logic [7:0]         cfg_rd [2];

  assign setup    = psel & ~penable;
  // writes land only in the access cycle the master samples pready
  assign acc_wr   = psel & penable & pready_r & pwrite;
  assign idx      = paddr[8:2];
  assign bad_addr = (paddr[1:0] != 2'b00) | (|(paddr >> 9));
  assign loc      = acb_pkg::acb_decode(page_r, idx);
  assign page_hit = (idx == acb_pkg::PAGE_IDX) & ~bad_addr;
  assign cfg_hit[0] = (page_r == acb_pkg::REC_A_PG) & (idx == acb_pkg::CFG_IDX) & ~bad_addr;
  assign cfg_hit[1] = (page_r == acb_pkg::PLAY_A_PG) & (idx == acb_pkg::CFG_IDX) & ~bad_addr;
  assign cfg_wr   = cfg_hit & {2{acc_wr}};

  assign pwr_up = {play_pwr_up, rec_pwr_up};
  assign frame  = {play_frame, rec_frame};

  // a powered channel would read coefficients mid-update
  assign blocked  = loc.hit & ~en_r[loc.path] & pwr_up[loc.path];
  // in adaptive mode the host always lands on the filter-free buffer
  assign host_buf = en_r[loc.path] ? ~own_r[loc.path] : loc.bsel;

  assign bank_we[0] = acc_wr & loc.hit & ~blocked & ~bad_addr & (loc.path == 1'b0);
  assign bank_we[1] = acc_wr & loc.hit & ~blocked & ~bad_addr & (loc.path == 1'b1);

  // ***********************************
  // adaptive swap, per path
  // ***********************************
  assign swap    = req_r & en_r & frame;
  // buffer A feeds the filter whenever adaptive mode is off
  assign eng_buf = en_r & own_r;
  assign eng_idx[0] = rec_coef_idx;
  assign eng_idx[1] = play_coef_idx;

  for (genvar p = 0; p < 2; p++) begin : g_path
    assign cfg_rd[p] = {5'b00000, en_r[p], own_r[p], req_r[p]};

    acb_coef_bank #(
      .DEPTH (acb_pkg::BUF_BYTES)
    ) u_bank (
      .pclk       (pclk),
      .presetn    (presetn),
      .host_we    (bank_we[p]),
      .host_buf   (host_buf),
      .host_addr  (loc.addr),
      .host_wdata (pwdata[7:0]),
      .host_rdata (bank_rd[p]),
      .eng_buf    (eng_buf[p]),
      .eng_idx    (eng_idx[p]),
      .eng_coef   (eng_coef[p])
    );
  end

  always_comb begin
    en_nxt  = en_r;
    own_nxt = own_r ^ swap;
    req_nxt = req_r & ~swap;
    for (int p = 0; p < 2; p++) begin
      if (cfg_wr[p]) begin
        en_nxt[p]  = pwdata[acb_pkg::CFG_EN_BIT];
        // a request made in the swap cycle stays for the next frame
        req_nxt[p] = pwdata[acb_pkg::CFG_SWAP_BIT] & pwdata[acb_pkg::CFG_EN_BIT];
      end
    end
  end

  // ***********************************
  // apb answer, one access cycle, no wait states
  // ***********************************
  assign page_nxt   = (acc_wr & page_hit) ? pwdata[7:0] : page_r;
  assign pready_nxt = setup;

  always_comb begin
    prdata_nxt  = 32'h00000000;
    pslverr_nxt = 1'b0;
    if (setup) begin
      if (bad_addr) begin
        pslverr_nxt = 1'b1;
      end else if (page_hit) begin
        prdata_nxt = {24'h000000, page_r};
      end else if (cfg_hit[0]) begin
        prdata_nxt = {24'h000000, cfg_rd[0]};
      end else if (cfg_hit[1]) begin
        prdata_nxt = {24'h000000, cfg_rd[1]};
      end else if (blocked) begin
        pslverr_nxt = 1'b1;
      end else if (loc.hit) begin
        prdata_nxt = {24'h000000, bank_rd[loc.path]};
      end
    end else if (psel & penable & pready_r) begin
      prdata_nxt  = 32'h00000000;
    end else begin
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_r    <= acb_pkg::PAGE_RST;
      en_r      <= {2{acb_pkg::CFG_EN_RST}};
      own_r     <= {2{acb_pkg::CFG_OWN_RST}};
      req_r     <= {2{acb_pkg::CFG_SWAP_RST}};
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      page_r    <= page_nxt;
      en_r      <= en_nxt;
      own_r     <= own_nxt;
      req_r     <= req_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign rec_coef  = eng_coef[0];
  assign play_coef = eng_coef[1];

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  // the answer stands for the access cycle only, then drops
  property p_answer_next;
    s_setup |=> pready ##1 !pready;
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("no answer after setup");

  property p_page_write;
    s_setup ##1 s_access ##0 (pwrite && idx == 7'h00 && !bad_addr)
      |=> page_r == $past(pwdata[7:0]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page pointer not written");

  property p_page_read;
    (setup && !pwrite && page_hit) |=> prdata == {24'h000000, $past(page_r)};
  endproperty
  a_page_read: assert property (p_page_read) else $error("page pointer misread");

  property p_play_swap;
    (req_r[1] && en_r[1] && play_frame && !cfg_wr[1])
      |=> !req_r[1] && own_r[1] != $past(own_r[1]);
  endproperty
  a_play_swap: assert property (p_play_swap) else $error("playback swap wrong");

  property p_rec_swap;
    (req_r[0] && en_r[0] && rec_frame && !cfg_wr[0])
      |=> !req_r[0] && own_r[0] != $past(own_r[0]);
  endproperty
  a_rec_swap: assert property (p_rec_swap) else $error("record swap wrong");

  property p_own_hold;
    !(en_r[1] && req_r[1] && play_frame) |=> $stable(own_r[1]);
  endproperty
  a_own_hold: assert property (p_own_hold) else $error("ownership moved without swap");

  property p_req_needs_en;
    req_r[1] |-> en_r[1];
  endproperty
  a_req_needs_en: assert property (p_req_needs_en) else $error("swap pending while off");

  property p_gate;
    (setup && blocked && !bad_addr && !page_hit && !(|cfg_hit))
      |=> pslverr && prdata == 32'h00000000;
  endproperty
  a_gate: assert property (p_gate) else $error("powered channel not gated");

  property p_no_gate_write;
    blocked |-> bank_we == 2'b00;
  endproperty
  a_no_gate_write: assert property (p_no_gate_write) else $error("gated write reached bank");

  property p_redirect;
    (loc.hit && en_r[loc.path]) |-> host_buf != eng_buf[loc.path];
  endproperty
  a_redirect: assert property (p_redirect) else $error("host hit filter buffer");

  property p_cfg_high_zero;
    (setup && (|cfg_hit)) |=> prdata[31:3] == 29'h00000000;
  endproperty
  a_cfg_high_zero: assert property (p_cfg_high_zero) else $error("reserved bits set");

  property p_rsvd_read;
    (setup && !bad_addr && idx != acb_pkg::PAGE_IDX && idx < acb_pkg::COEF_FIRST_IDX
      && !(|cfg_hit)) |=> !pslverr && prdata == 32'h00000000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved index not zero");

  property p_cfg_write;
    s_setup ##1 s_access ##0 (pwrite && cfg_hit[1])
      |=> en_r[1] == $past(pwdata[acb_pkg::CFG_EN_BIT]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("enable bit not written");

  property p_rec_own_hold;
    !(en_r[0] && req_r[0] && rec_frame) |=> $stable(own_r[0]);
  endproperty
  a_rec_own_hold: assert property (p_rec_own_hold) else $error("record owner moved");

  property p_rec_req_needs_en;
    req_r[0] |-> en_r[0];
  endproperty
  a_rec_req_needs_en: assert property (p_rec_req_needs_en) else $error("record swap while off");

endmodule : acb_ctrl
`default_nettype wire

// ### dv/acb_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module acb_engine_model #(
  parameter int FRAME_LEN = 16
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // channel power
  input  wire logic       pwr_up,
  // engine requests
  output logic            frame,
  output logic      [7:0] coef_idx
);
  logic [7:0] cnt_r;

  // a powered-down channel makes no frame boundary, so no swap can land then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r    <= 8'h00;
      frame    <= 1'b0;
      coef_idx <= 8'h00;
    end else begin
      coef_idx <= coef_idx + 8'h01;
      cnt_r    <= (cnt_r == 8'(FRAME_LEN - 1)) ? 8'h00 : cnt_r + 8'h01;
      frame    <= pwr_up && (cnt_r == 8'h00);
    end
  end
endmodule : acb_engine_model
`default_nettype wire

// ### dv/acb_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module acb_ctrl_tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pwr;
  logic [1:0]  frame;
  logic [7:0]  idx [2];
  logic [23:0] coef [2];
  logic [7:0]  rd;
  logic        er;
  logic [23:0] va;
  logic [23:0] vb;
  int          err_total;
  int          checked;
  int          seed;
  int          n;
  int          t;

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  acb_ctrl #(.ADDR_W(12)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rec_pwr_up(pwr[0]), .rec_frame(frame[0]), .rec_coef_idx(idx[0]), .rec_coef(coef[0]),
    .play_pwr_up(pwr[1]), .play_frame(frame[1]), .play_coef_idx(idx[1]), .play_coef(coef[1])
  );
  acb_engine_model rec_eng (.pclk(pclk), .presetn(presetn), .pwr_up(pwr[0]),
                            .frame(frame[0]), .coef_idx(idx[0]));
  acb_engine_model play_eng (.pclk(pclk), .presetn(presetn), .pwr_up(pwr[1]),
                             .frame(frame[1]), .coef_idx(idx[1]));

  // ****************
  // expectations and checks
  // ****************
  function automatic logic [7:0] fpg(input int p, input int b);
    return p ? (b ? acb_pkg::PLAY_B_PG : acb_pkg::PLAY_A_PG)
             : (b ? acb_pkg::REC_B_PG : acb_pkg::REC_A_PG);
  endfunction : fpg

  // {page, index} of linear byte l of a buffer
  function automatic logic [14:0] loc(input int p, input int b, input int l);
    return {fpg(p, b) + 8'(l / 120), 7'(8 + l % 120)};
  endfunction : loc

  function automatic logic [14:0] cfgad(input int p);
    return {fpg(p, 0), acb_pkg::CFG_IDX};
  endfunction : cfgad

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ****************
  // bus tasks
  // ****************
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) err_total++;
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic acc(input logic w, input logic [14:0] a, input logic [7:0] d);
    apb(1'b1, 12'h000, a[14:7]);
    apb(w, {3'b000, a[6:0], 2'b00}, d);
  endtask : acc

  task automatic rchk(input logic [14:0] a, input logic [7:0] e, input logic ee);
    acc(1'b0, a, 8'h00);
    chk({15'h0000, er, rd}, {15'h0000, ee, e});
  endtask : rchk

  task automatic wchk(input logic [14:0] a, input logic [7:0] d, input logic ee);
    acc(1'b1, a, d);
    chk({23'h000000, er}, {23'h000000, ee});
  endtask : wchk

  // byte 4n carries bits 23:16, then 15:8, then 7:0
  task automatic wcoef(input int p, input int b, input int c, input logic [23:0] v);
    for (int k = 0; k < 3; k++) wchk(loc(p, b, 4 * c + k), v[23 - 8 * k -: 8], 1'b0);
  endtask : wcoef

  task automatic cchk(input int p, input int c, input logic [23:0] e);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (idx[p] !== 8'(c) && k < 300);
    if (k == 300) err_total++;
    @(posedge pclk);
    chk(coef[p], e);
  endtask : cchk

  // ****************
  // sequence
  // ****************
  initial begin
    seed = 7549;
    err_total = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pwr = 2'b00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 8'h00);
    chk({16'h0000, rd}, 24'h000000);
    for (int p = 0; p < 2; p++) begin
      rchk(cfgad(p), 8'h00, 1'b0);
      for (int i = 0; i < 3; i++) begin
        n = $random(seed) & 255;
        apb(1'b1, 12'h000, 8'(n));
        apb(1'b0, 12'h000, 8'h00);
        chk({16'h0000, rd}, 24'(n));
      end
      for (int i = 1; i < 8; i++) begin
        // the host may only write zero to reserved registers
        wchk({fpg(p, 1) + 8'h01, 7'(i)}, 8'h00, 1'b0);
        rchk({fpg(p, 1) + 8'h01, 7'(i)}, 8'h00, 1'b0);
      end
      wchk(cfgad(p), 8'h02, 1'b0);
      rchk(cfgad(p), 8'h00, 1'b0);
      for (int k = 0; k < 5; k++) begin
        n = (k == 0) ? 0 : (k == 1) ? 29 : (k == 2) ? 30 : (k == 3) ? 255 : $random(seed) & 255;
        va = 24'($random(seed));
        vb = 24'($random(seed));
        wcoef(p, 0, n, va);
        wcoef(p, 1, n, vb);
        rchk(loc(p, 1, 4 * n), vb[23:16], 1'b0);
        cchk(p, n, va);
      end
      pwr[p] <= 1'b1;
      wchk(loc(p, 0, 0), 8'h55, 1'b1);
      rchk(loc(p, 1, 0), 8'h00, 1'b1);
      wchk(cfgad(p), 8'h04, 1'b0);
      vb = 24'($random(seed));
      wcoef(p, 0, n, vb);
      rchk(loc(p, 1, 4 * n), vb[23:16], 1'b0);
      cchk(p, n, va);
      pwr[p] <= 1'b0;
      wchk(cfgad(p), 8'h05, 1'b0);
      rchk(cfgad(p), 8'h05, 1'b0);
      pwr[p] <= 1'b1;
      t = 0;
      do begin
        acc(1'b0, cfgad(p), 8'h00);
        t++;
      end while (rd[0] !== 1'b0 && t < 20);
      chk({16'h0000, rd}, 24'h000006);
      cchk(p, n, vb);
      rchk(loc(p, 0, 4 * n), va[23:16], 1'b0);
      wchk(cfgad(p), 8'h01, 1'b0);
      rchk(cfgad(p), 8'h02, 1'b0);
      pwr[p] <= 1'b0;
    end
    // reset in mid-run: owner flag of playback was left at one
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 8'h00);
    chk({16'h0000, rd}, 24'h000000);
    rchk(cfgad(1), 8'h00, 1'b0);
    apb(1'b0, 12'h200, 8'h00);
    chk({15'h0000, er, rd}, 24'h000100);
    apb(1'b1, 12'h000, 8'h07);
    apb(1'b1, 12'h001, 8'h33);
    chk({23'h000000, er}, 24'h000001);
    apb(1'b0, 12'h000, 8'h00);
    chk({16'h0000, rd}, 24'h000007);
    summarize();
  end

  // a hang ends the run as a mismatch
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    summarize();
  end
endmodule : acb_ctrl_tb
`default_nettype wire
